// ### stoi_pkg.sv
// constants and types for the safe torque off interlock
package stoi_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int DISCREPANCY_MS = 50;
   localparam int DISCREPANCY_CYCLES = (CLK_HZ / 1000) * DISCREPANCY_MS;
   localparam int RESPONSE_MS = 50;
   localparam int RESPONSE_CYCLES = (CLK_HZ / 1000) * RESPONSE_MS;
   localparam int CNT_W = 22;
   localparam logic [3:0] FUNC_HOLD = 4'h6;
   localparam int FUNC_W = 4;
   typedef enum logic [1:0] {
      STOI_SHUTOFF,
      STOI_READY,
      STOI_RUNNING
   } stoi_state_t;
endpackage

// ### stoi_window_timer.sv
// saturating counter that times how long a condition has held
`timescale 1ns/1ps
module stoi_window_timer #(
   parameter int CNT_W = 22,
   parameter logic [21:0] LIMIT = 22'h1E8480
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic active,
   output logic expired
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic expired;
   } stoi_timer_t;

   stoi_timer_t cur;
   stoi_timer_t next_cur;

   // count while active, restart whenever the condition drops
   always_comb begin
      next_cur = cur;
      if (!active) begin
         next_cur.count = '0;
         next_cur.expired = 1'b0;
      end else if (cur.count >= CNT_W'(LIMIT)) begin
         next_cur.expired = 1'b1;
      end else begin
         next_cur.count = cur.count + CNT_W'(1);
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign expired = cur.expired;
endmodule

// ### stoi_interlock.sv
// dual-channel enable interlock with discrepancy alarm and restart prevention
`timescale 1ns/1ps
module stoi_interlock #(
   parameter int DISCREPANCY_CYCLES = stoi_pkg::DISCREPANCY_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable_channel_a,
   input wire logic enable_channel_b,
   input wire logic forward_run_command,
   input wire logic digital_input_one,
   input wire logic [3:0] input_one_function_select,
   input wire logic gate_a_feedback,
   input wire logic gate_b_feedback,
   output logic output_enable_a,
   output logic output_enable_b,
   output logic torque_shutoff_state,
   output logic ready_to_run,
   output logic running,
   output logic enable_discrepancy_alarm,
   output logic shutoff_path_fault_alarm
);
   typedef struct packed {
      stoi_pkg::stoi_state_t state;
      logic run_latched;
      logic fwd_prev;
      logic alarm;
      logic fault;
      logic gate_a;
      logic gate_b;
   } stoi_core_t;

   stoi_core_t cur;
   stoi_core_t next_cur;
   logic disagree;
   logic window_expired;
   logic hold_active;
   logic fwd_rise;
   logic both_on;
   logic any_off;
   logic stop_cause;
   logic hold_selected;

   // true when the registered state equals the one asked about
   function automatic logic stoi_in_state(
      input stoi_pkg::stoi_state_t now,
      input stoi_pkg::stoi_state_t want
   );
      logic hit;
      hit = (now == want);
      return hit;
   endfunction

   // one gate path: its own channel, no fault, running next
   function automatic logic stoi_gate_drive(
      input logic channel_on,
      input logic fault_seen,
      input stoi_pkg::stoi_state_t next_state
   );
      logic drive;
      drive = channel_on && !fault_seen;
      drive = drive && (next_state == stoi_pkg::STOI_RUNNING);
      return drive;
   endfunction

   // gate readback differs from what was driven one edge earlier
   function automatic logic stoi_readback_bad(
      input logic driven,
      input logic seen
   );
      logic bad;
      bad = (driven != seen);
      return bad;
   endfunction

   // channels disagree; timer restarts whenever they agree again
   assign disagree = enable_channel_a ^ enable_channel_b;

   // discrepancy window, keeps running in every state
   stoi_window_timer #(
      .CNT_W(stoi_pkg::CNT_W),
      .LIMIT(22'(DISCREPANCY_CYCLES))
   ) u_window (
      .clk(clk),
      .rst_n(rst_n),
      .active(disagree),
      .expired(window_expired)
   );

   // hold function only when input one is assigned to it
   assign hold_active = hold_selected && digital_input_one;

   // forward edge: high now, low at the last sample
   assign fwd_rise = forward_run_command && !cur.fwd_prev;

   // both channels on, or at least one dropped
   assign both_on = enable_channel_a && enable_channel_b;
   assign any_off = !both_on;

   // anything that forces torque shutoff from ready or running
   assign stop_cause = any_off
                       || cur.alarm
                       || cur.fault;

   // input one decoded as the hold terminal, level looked at above
   assign hold_selected = (input_one_function_select == stoi_pkg::FUNC_HOLD);

   // sequence: shutoff, ready, running
   // a forward edge seen outside ready is dropped on purpose,
   // so enables coming back never start the output by themselves
   always_comb begin
      next_cur = cur;
      next_cur.fwd_prev = forward_run_command;
      // alarm latches; cleared only by reset
      if (window_expired) begin
         next_cur.alarm = 1'b1;
      end
      // gate driven but feedback says off, or off but feedback says on
      // each path checked alone, so one stuck path is still caught
      if (stoi_readback_bad(cur.gate_a, gate_a_feedback)
          || stoi_readback_bad(cur.gate_b, gate_b_feedback)) begin
         next_cur.fault = 1'b1;
      end

      case (cur.state)
         stoi_pkg::STOI_SHUTOFF: begin
            // latched run dropped on every shutoff
            next_cur.run_latched = 1'b0;
            // alarm or fault keeps the drive here until restart
            if (both_on && !cur.alarm && !cur.fault) begin
               next_cur.state = stoi_pkg::STOI_READY;
            end
         end
         stoi_pkg::STOI_READY: begin
            // needs a fresh forward edge, so enables alone never start it
            // alarm or fault latched here also ends ready
            if (stop_cause) begin
               next_cur.state = stoi_pkg::STOI_SHUTOFF;
            end else if (fwd_rise) begin
               next_cur.state = stoi_pkg::STOI_RUNNING;
               next_cur.run_latched = hold_active;
            end
         end
         stoi_pkg::STOI_RUNNING: begin
            // coast whatever the run command says
            if (stop_cause) begin
               next_cur.state = stoi_pkg::STOI_SHUTOFF;
               next_cur.run_latched = 1'b0;
            end else if (!hold_active) begin
               // hold off: run follows the forward level
               next_cur.run_latched = 1'b0;
               if (!forward_run_command) begin
                  next_cur.state = stoi_pkg::STOI_READY;
               end
            end else if (forward_run_command) begin
               // hold on: forward high latches the run
               next_cur.run_latched = 1'b1;
            end else if (!cur.run_latched) begin
               // hold on but nothing latched: back to waiting
               next_cur.state = stoi_pkg::STOI_READY;
            end
         end
         default: begin
            // unused code falls back to the safe state
            next_cur.state = stoi_pkg::STOI_SHUTOFF;
         end
      endcase

      // each gate follows its own channel, one cycle latency
      // next state and next fault used, so a drop acts in one edge
      next_cur.gate_a = stoi_gate_drive(enable_channel_a,
                                        next_cur.fault,
                                        next_cur.state);
      next_cur.gate_b = stoi_gate_drive(enable_channel_b,
                                        next_cur.fault,
                                        next_cur.state);
   end

   // state register; restart clears alarms as well
   // gates come up off, so the first readback check sees agreement
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // redundant enables straight from their own flip-flops
   assign output_enable_a = cur.gate_a;
   assign output_enable_b = cur.gate_b;

   // one-hot view of the sequence state
   assign torque_shutoff_state = stoi_in_state(cur.state, stoi_pkg::STOI_SHUTOFF);
   assign ready_to_run = stoi_in_state(cur.state, stoi_pkg::STOI_READY);
   assign running = stoi_in_state(cur.state, stoi_pkg::STOI_RUNNING);

   // latched alarms, cleared only by a restart
   assign enable_discrepancy_alarm = cur.alarm;
   assign shutoff_path_fault_alarm = cur.fault;
endmodule

// ### stoi_interlock_properties.sv
// assertions for the safe torque off interlock
`timescale 1ns/1ps
module stoi_interlock_properties #(parameter int DISCREPANCY_CYCLES = stoi_pkg::DISCREPANCY_CYCLES) (
   input wire logic clk, rst_n, enable_channel_a, enable_channel_b, forward_run_command,
   input wire logic gate_a_feedback, gate_b_feedback, output_enable_a, output_enable_b,
   input wire logic torque_shutoff_state, ready_to_run, running,
   input wire logic enable_discrepancy_alarm, shutoff_path_fault_alarm);
   // short views of the watched enable channels and outputs
   wire logic both = enable_channel_a && enable_channel_b;
   wire logic off = !output_enable_a && !output_enable_b;
   wire logic alarm = enable_discrepancy_alarm;
   wire logic fault = shutoff_path_fault_alarm;
   int cnt;
   // samples of unbroken channel disagreement
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt <= 0;
      else cnt <= (enable_channel_a != enable_channel_b) ? cnt + 1 : 0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_channel_low_off: assert property (
      !both |=> off && torque_shutoff_state && !running) else $error("output left on");
   a_ready_quiet: assert property (ready_to_run |-> off && !running)
      else $error("ready drives output");
   a_alarm_held: assert property (alarm |=> alarm) else $error("alarm dropped");
   a_alarm_not_early: assert property (
      $rose(alarm) |-> $past(cnt) >= DISCREPANCY_CYCLES - 1) else $error("alarm early");
   a_alarm_in_time: assert property (
      cnt == DISCREPANCY_CYCLES + 3 |-> alarm) else $error("alarm missing");
   a_start_on_edge: assert property ($rose(running) |-> $past(ready_to_run) &&
      $past(forward_run_command) && !$past(forward_run_command, 2)) else $error("bad start");
   a_latched_stop: assert property ((alarm || fault) |=> torque_shutoff_state && off)
      else $error("runs with alarm");
   a_fault_cause: assert property ($rose(fault) |-> $past(gate_a_feedback !=
      output_enable_a || gate_b_feedback != output_enable_b)) else $error("false fault");
   c_run: cover property ($rose(running));
   c_alarm: cover property ($rose(alarm));
   c_fault: cover property ($rose(fault));
endmodule
bind stoi_interlock stoi_interlock_properties
   #(.DISCREPANCY_CYCLES(DISCREPANCY_CYCLES)) i_props (.*);

// ### stoi_relay_model.sv
// emergency stop relay that drives the two enable channels
`timescale 1ns/1ps
module stoi_relay_model (
   input wire logic clk,
   input wire logic estop,
   input wire logic [7:0] lag,
   output logic enable_channel_a = 1'b0,
   output logic enable_channel_b = 1'b0);
   logic [7:0] n = 8'h00;
   // channel b follows channel a after lag cycles
   always @(posedge clk) begin
      enable_channel_a <= !estop;
      n <= (enable_channel_b == !estop) ? 8'h00 : n + 8'h01;
      if (n >= lag) enable_channel_b <= !estop;
   end
endmodule

// ### stoi_interlock_bench.sv
// self-checking bench for the safe torque off interlock
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module stoi_interlock_bench;
   logic clk = 0, rst_n = 0, estop = 1, forward_run_command = 0, digital_input_one = 0;
   logic flt = 0, enable_channel_a, enable_channel_b, output_enable_a, output_enable_b;
   logic torque_shutoff_state, ready_to_run, running, enable_discrepancy_alarm;
   logic shutoff_path_fault_alarm;
   logic [3:0] input_one_function_select = 4'h0;
   logic [7:0] lag = 8'h00;
   logic [6:0] q[$];
   logic [6:0] want;
   int n_fail = 0, num_checks = 0, seed = 32'h20C2;
   event ev;
   wire logic gate_a_feedback = output_enable_a ^ flt;
   wire logic gate_b_feedback = output_enable_b;
   wire logic [6:0] obs = {torque_shutoff_state, ready_to_run, running, output_enable_a,
      output_enable_b, enable_discrepancy_alarm, shutoff_path_fault_alarm};
   localparam logic [6:0] SH = 7'h40, RDY = 7'h20, RUN = 7'h1C, ALM = 7'h42, FLT = 7'h41;
   stoi_interlock #(.DISCREPANCY_CYCLES(20)) i_stoi_interlock (.*);
   stoi_relay_model i_stoi_relay_model (.*);
   // 40 MHz clock
   initial forever #12.5 clk = ~clk;
   // wait, then note the expected outputs
   task automatic step(input int n, input logic [6:0] e);
      repeat (n) @(negedge clk);
      q.push_back(e);
      -> ev;
   endtask
   // oldest note against the outputs
   always @(ev) begin
      want = q.pop_front();
      `CHK(obs, want)
   end
   task automatic restart();
      rst_n = 0;
      repeat (10) @(negedge clk);
      rst_n = 1;
   endtask
   task automatic close_out();
      @(posedge clk);
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (2000) @(negedge clk);
      n_fail++;
      close_out();
   end
   // scenarios, driven on the falling edge
   initial begin
      restart();
      step(1, SH);
      estop = 0;
      step(3, RDY);
      forward_run_command = 1;
      step(3, RUN);
      input_one_function_select = 4'h6;
      digital_input_one = 1;
      step(2, RUN);
      forward_run_command = 0;
      step(3, RUN);
      estop = 1;
      step(3, SH);
      estop = 0;
      step(3, RDY);
      forward_run_command = 1;
      step(3, RUN);
      input_one_function_select = 4'({$random(seed)} % 6);
      forward_run_command = 0;
      step(3, RDY);
      $display("hold and restart test done");
      lag = 8'h0A;
      estop = 1;
      step(2, SH);
      step(40, SH);
      estop = 0;
      step(40, RDY);
      lag = 8'h3C;
      estop = 1;
      step(3, SH);
      step(40, ALM);
      estop = 0;
      step(80, ALM);
      restart();
      step(3, RDY);
      $display("discrepancy test done");
      forward_run_command = 1;
      step(3, RUN);
      flt = 1;
      step(3, FLT);
      $display("fault test done");
      close_out();
   end
endmodule
